/* spm_pkg.sv */
/*
  Shared constants, types and helpers for the spindle parameter menu.
  Assumes a single 40 MHz clock. Speeds in thousands per minute are 7 bits wide.
  Speeds in rpm are 17 bits wide, and voltages arrive in millivolts.
*/
package spm_pkg;

  // clock and timing
  localparam int CLK_HZ = 40000000;
  localparam int CLK_PER_MS = CLK_HZ / 1000;
  localparam int HOLD_MS = 3000;      // reset held at power-on
  localparam int DEBOUNCE_MS = 20;    // switch settle time
  localparam int BLINK_MS = 500;      // display and led alternation
  localparam int BEEP_MS = 100;       // buzzer half period
  localparam int HOLD_CYCLES = HOLD_MS * CLK_PER_MS;
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_MS * CLK_PER_MS;
  localparam int BLINK_CYCLES = BLINK_MS * CLK_PER_MS;
  localparam int BEEP_CYCLES = BEEP_MS * CLK_PER_MS;
  localparam int TMR_W = 27;
  localparam logic [2:0] BEEP_HALVES = 3'h6; // three beeps, on and off

  // parameter indices
  localparam logic [3:0] P_FIRST = 4'h1;
  localparam logic [3:0] P_FIXED = 4'h3;
  localparam logic [3:0] P_MAX = 4'h4;
  localparam logic [3:0] P_EXT = 4'h5;
  localparam logic [3:0] P_START = 4'h6;
  localparam logic [3:0] P_AIR = 4'h7;
  localparam logic [3:0] P_SCALE = 4'h8;
  localparam logic [3:0] P_LAST = 4'h8;
  localparam logic [3:0] P_CONFIRM = 4'h9;
  localparam logic [8:1] PARAM_DEFAULTS = 8'h00; // every parameter off

  // speeds
  localparam logic [6:0] SPEED_MIN_K = 7'h01;   // 1,000 per minute
  localparam logic [6:0] SPEED_MAX_K = 7'h50;   // 80,000 per minute
  localparam logic [6:0] PULSE_MIN_K = 7'h00;
  localparam logic [16:0] RPM_PER_K = 17'h003e8;  // 1,000
  localparam logic [16:0] ABS_CAP_RPM = 17'h13880; // 80,000
  localparam logic [16:0] AIR_CAP_RPM = 17'h07530; // 30,000
  localparam logic [16:0] SCALE_CAP_RPM = 17'h0ea60; // 60,000
  localparam logic [20:0] MV_MUL_PLAIN = 21'h00000a;  // 10,000 per volt
  localparam logic [20:0] MV_MUL_SCALED = 21'h000014; // 10,000/1.5 as 20/3 per mV
  localparam logic [20:0] MV_DIV_SCALED = 21'h000003;

  typedef enum logic [2:0] {
    ST_BOOT = 3'h0,
    ST_BEEP = 3'h1,
    ST_WAIT_REL = 3'h2,
    ST_RUN = 3'h3,
    ST_SELECT = 3'h4,
    ST_EDIT = 3'h5,
    ST_CONFIRM = 3'h6
  } menu_state_t;

  typedef enum logic [2:0] {
    DISP_BLANK = 3'h0,
    DISP_PARAM = 3'h1,
    DISP_OFF = 3'h2,
    DISP_ON = 3'h3,
    DISP_NUM = 3'h4
  } disp_t;

  // thousands to rpm
  function automatic logic [16:0] kilo_to_rpm(input logic [6:0] k);
    kilo_to_rpm = 17'(17'(k) * RPM_PER_K);
  endfunction

  // millivolts to rpm, plain or compatibility scaling
  function automatic logic [16:0] volt_to_rpm(input logic [13:0] mv, input logic scaled);
    logic [20:0] wide;
    wide = scaled ? 21'((21'(mv) * MV_MUL_SCALED) / MV_DIV_SCALED) : 21'(21'(mv) * MV_MUL_PLAIN);
    volt_to_rpm = 17'(wide);
  endfunction

  function automatic logic [16:0] min_rpm(input logic [16:0] a, input logic [16:0] b);
    min_rpm = (a < b) ? a : b;
  endfunction

  // keep a stored speed inside the settable range
  function automatic logic [6:0] clamp_k(input logic [6:0] k);
    clamp_k = (k < SPEED_MIN_K) ? SPEED_MIN_K : ((k > SPEED_MAX_K) ? SPEED_MAX_K : k);
  endfunction

endpackage

/* switch_debounce.sv */
/*
  Debounce and press detection for one panel switch.
  Assumes the raw input is already synchronous to i_clk and that the reset is synchronised.
*/
`timescale 1ns/10ps
`default_nettype none

module switch_debounce #(
  parameter int DB_CYC = 800000
) (
  input wire logic i_clk,   // system clock
  input wire logic i_rstn,  // synchronised reset, low active
  input wire logic i_raw,   // raw switch level, high pressed
  output logic o_level,     // settled level
  output logic o_press      // one-cycle pulse on each settled press
);

  logic [26:0] cnt;

  // the level only follows the raw input after it has held steady, so that bounce is ignored
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt <= 27'h0000000;
      o_level <= 1'b0;
    end else if (i_raw == o_level) begin
      cnt <= 27'h0000000;
    end else if (cnt == 27'(DB_CYC - 1)) begin
      cnt <= 27'h0000000;
      o_level <= i_raw;
    end else begin
      cnt <= cnt + 27'h0000001;
    end
  end

  // press pulse is the settled rising edge
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_press <= 1'b0;
    end else begin
      o_press <= (cnt == 27'(DB_CYC - 1)) && i_raw && !o_level;
    end
  end

endmodule

`default_nettype wire

/* spindle_param_menu.sv */
/*
  Parameter menu and speed command logic of the spindle control unit.
  Assumes synchronous panel and connector inputs, and external non-volatile storage.
  The storage presents saved values while reset is asserted and takes one-cycle write strobes.
*/
//
// Contract
// - start press toggles the maximum-speed parameter between off and on
// - enabled limit alternates on code and speed; adjust steps 1 to 80 thousand
// - reset press stores the shown choice, then the display shows parameter code
// - adjust press in setting mode moves selection to the next parameter
// - external source parameter picks voltage input or pulse counting
// - pulse mode: up/down open raises, closed lowers, 1,000 per pulse
// - start method picks direction plus start, or forward and reverse starts
// - air override allows running without air, capped at 30,000
// - scaling off: speed equals millivolts times ten
// - scaling on: speed equals volts times 10,000 divided by 1.5
// - scaling on caps speed at 60,000
// - confirm view steps parameters by start, alternating code and setting
// - after the last, start returns to selection; reset ends confirm view
// - factory default of every parameter is off
// - power-up restores panel state and all parameters
// - reset held 3 s at power-on enters setting mode, three beeps, led flashes
// - presets live in non-volatile storage
`timescale 1ns/10ps
`default_nettype none

module spindle_param_menu
  import spm_pkg::*;
#(
  parameter int HOLD_CYC = HOLD_CYCLES,
  parameter int DB_CYC = DEBOUNCE_CYCLES,
  parameter int BLINK_CYC = BLINK_CYCLES,
  parameter int BEEP_CYC = BEEP_CYCLES
) (
  input wire logic i_clk,                   // 40 MHz clock
  input wire logic i_rstn,                  // power-on reset, low active
  input wire logic i_start_sw,              // start switch, high pressed
  input wire logic i_reset_sw,              // error reset switch, high pressed
  input wire logic i_adjust_sw,             // speed adjust switch, high pressed
  input wire logic i_auto_mode,             // panel in auto mode
  input wire logic [13:0] i_voltage_speed_in, // speed voltage in millivolts
  input wire logic i_count_pulse_in,        // speed count pulse
  input wire logic i_up_down_select,        // high open: increase
  input wire logic i_dir_in,                // direction, high reverse
  input wire logic i_start_in,              // start level
  input wire logic i_forward_start,         // forward start level
  input wire logic i_reverse_start,         // reverse start level
  input wire logic i_nv_blank,              // storage never written
  input wire logic [8:1] i_nv_enable,       // stored on/off per parameter
  input wire logic [6:0] i_nv_fixed_speed,  // stored fixed speed, thousands
  input wire logic [6:0] i_nv_max_speed,    // stored speed limit, thousands
  input wire logic [6:0] i_nv_panel_speed,  // stored panel speed, thousands
  input wire logic i_nv_panel_dir,          // stored direction
  input wire logic i_nv_panel_auto,         // stored auto/manual
  input wire logic [3:0] i_nv_panel_gear,   // stored gear ratio
  output logic [2:0] o_disp_kind,           // display content kind
  output logic [6:0] o_disp_value,          // parameter number or thousands
  output logic o_start_led,                 // start indicator
  output logic o_buzzer,                    // buzzer drive
  output logic o_setting_mode,              // menu active
  output logic [16:0] o_speed_cmd,          // commanded speed, rpm
  output logic o_run,                       // run request
  output logic o_run_reverse,               // reverse direction
  output logic o_air_monitor_en,            // cooling air check enabled
  output logic o_nv_we,                     // storage write strobe
  output logic [3:0] o_nv_index,            // parameter written
  output logic o_nv_enable,                 // on/off written
  output logic [6:0] o_nv_speed,            // speed written, thousands
  output logic [6:0] o_resume_speed,        // restored panel speed
  output logic o_resume_dir,                // restored direction
  output logic o_resume_auto,               // restored control mode
  output logic [3:0] o_resume_gear          // restored gear ratio
);

  logic rst_meta;
  logic rst_n;
  logic loaded;
  logic start_press;
  logic reset_press;
  logic adjust_press;
  logic reset_level;
  logic cnt_prev;
  logic cnt_rise;
  menu_state_t state;
  logic [3:0] sel;
  logic [3:0] view;
  logic edit_en;
  logic [6:0] edit_k;
  logic commit;
  logic [TMR_W-1:0] tmr;
  logic [2:0] halves;
  logic [TMR_W-1:0] blink_cnt;
  logic blink;
  logic [8:1] param_en;
  logic [6:0] fixed_k;
  logic [6:0] max_k;
  logic [6:0] pulse_k;
  logic [16:0] next_speed;
  logic setting;

  function automatic logic has_speed(input logic [3:0] idx);
    has_speed = (idx == P_FIXED) || (idx == P_MAX);
  endfunction

  function automatic logic [3:0] next_sel(input logic [3:0] idx);
    next_sel = (idx == P_CONFIRM) ? P_FIRST : 4'(idx + 4'h1);
  endfunction

  // reset release through two flops
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  switch_debounce #(.DB_CYC(DB_CYC)) u_db_start (
    .i_clk(i_clk), .i_rstn(rst_n), .i_raw(i_start_sw), .o_level(), .o_press(start_press));
  switch_debounce #(.DB_CYC(DB_CYC)) u_db_reset (
    .i_clk(i_clk), .i_rstn(rst_n), .i_raw(i_reset_sw), .o_level(reset_level),
    .o_press(reset_press));
  switch_debounce #(.DB_CYC(DB_CYC)) u_db_adjust (
    .i_clk(i_clk), .i_rstn(rst_n), .i_raw(i_adjust_sw), .o_level(), .o_press(adjust_press));

  // count pulse edge; the controller drives it cleanly, so no debounce delay
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_prev <= 1'b0;
    end else begin
      cnt_prev <= i_count_pulse_in;
    end
  end
  assign cnt_rise = i_count_pulse_in && !cnt_prev;

  // one cycle after release the stored values are taken in
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      loaded <= 1'b0;
    end else begin
      loaded <= 1'b1;
    end
  end

  // panel state restored from storage at power-up
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_resume_speed <= SPEED_MIN_K;
      o_resume_dir <= 1'b0;
      o_resume_auto <= 1'b0;
      o_resume_gear <= 4'h0;
    end else if (!loaded) begin
      o_resume_speed <= clamp_k(i_nv_panel_speed);
      o_resume_dir <= i_nv_panel_dir;
      o_resume_auto <= i_nv_panel_auto;
      o_resume_gear <= i_nv_panel_gear;
    end
  end

  // defaults off; stored settings reloaded; commit updates the live copy
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      param_en <= PARAM_DEFAULTS;
      fixed_k <= SPEED_MIN_K;
      max_k <= SPEED_MAX_K;
    end else if (!loaded) begin
      param_en <= i_nv_blank ? PARAM_DEFAULTS : i_nv_enable;
      fixed_k <= clamp_k(i_nv_fixed_speed);
      max_k <= i_nv_blank ? SPEED_MAX_K : clamp_k(i_nv_max_speed);
    end else if (commit) begin
      param_en[sel] <= edit_en;
      if (sel == P_FIXED) begin
        fixed_k <= edit_k;
      end
      if (sel == P_MAX) begin
        max_k <= edit_k;
      end
    end
  end

  // storage write of the committed parameter
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_nv_we <= 1'b0;
      o_nv_index <= 4'h0;
      o_nv_enable <= 1'b0;
      o_nv_speed <= 7'h00;
    end else begin
      o_nv_we <= commit;
      if (commit) begin
        o_nv_index <= sel;
        o_nv_enable <= edit_en;
        o_nv_speed <= edit_k;
      end
    end
  end

  // menu sequencing; reset press wins over start, start over adjust
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_BOOT;
      sel <= P_FIRST;
      view <= P_FIRST;
      edit_en <= 1'b0;
      edit_k <= SPEED_MIN_K;
      commit <= 1'b0;
      tmr <= '0;
      halves <= 3'h0;
    end else begin
      commit <= 1'b0;
      case (state)
        // reset switch must stay held for the whole hold time
        ST_BOOT: begin
          if (!loaded) begin
            tmr <= '0;
          end else if (!i_reset_sw) begin
            state <= ST_RUN;
          end else if (tmr == TMR_W'(HOLD_CYC - 1)) begin
            state <= ST_BEEP;
            tmr <= '0;
            halves <= 3'h0;
          end else begin
            tmr <= tmr + TMR_W'(1);
          end
        end
        ST_BEEP: begin
          if (tmr == TMR_W'(BEEP_CYC - 1)) begin
            tmr <= '0;
            halves <= halves + 3'h1;
            if (halves == BEEP_HALVES - 3'h1) begin
              state <= ST_WAIT_REL;
            end
          end else begin
            tmr <= tmr + TMR_W'(1);
          end
        end
        ST_WAIT_REL: begin
          if (!reset_level) begin
            state <= ST_SELECT;
            sel <= P_FIRST;
          end
        end
        // adjust advances selection; start opens the chosen parameter
        ST_SELECT: begin
          if (start_press) begin
            if (sel == P_CONFIRM) begin
              state <= ST_CONFIRM;
              view <= P_FIRST;
            end else begin
              state <= ST_EDIT;
              edit_en <= param_en[sel];
              edit_k <= (sel == P_FIXED) ? fixed_k : max_k;
            end
          end else if (adjust_press) begin
            sel <= next_sel(sel);
          end
        end
        ST_EDIT: begin
          if (reset_press) begin
            // store and return to the code display
            commit <= 1'b1;
            state <= ST_SELECT;
          end else if (start_press) begin
            edit_en <= !edit_en;
          end else if (adjust_press) begin
            if (has_speed(sel) && edit_en) begin
              // speed step within 1 to 80 thousand, wrapping
              edit_k <= (edit_k == SPEED_MAX_K) ? SPEED_MIN_K : 7'(edit_k + 7'h01);
            end else begin
              sel <= next_sel(sel);
              state <= ST_SELECT;
            end
          end
        end
        ST_CONFIRM: begin
          if (reset_press) begin
            state <= ST_SELECT;
          end else if (start_press) begin
            if (view == P_LAST) begin
              // past the last, back to selection
              state <= ST_SELECT;
              sel <= P_FIRST;
            end else begin
              view <= 4'(view + 4'h1);
            end
          end
        end
        ST_RUN: begin
          tmr <= '0;
        end
        default: begin
          state <= ST_RUN;
        end
      endcase
    end
  end

  assign setting = (state == ST_SELECT) || (state == ST_EDIT) || (state == ST_CONFIRM);

  // alternation timer, shared by display and led so they move together
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      blink_cnt <= '0;
      blink <= 1'b0;
    end else if (blink_cnt == TMR_W'(BLINK_CYC - 1)) begin
      blink_cnt <= '0;
      blink <= !blink;
    end else begin
      blink_cnt <= blink_cnt + TMR_W'(1);
    end
  end

  // led flashes and buzzer sounds; display content
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_start_led <= 1'b0;
      o_buzzer <= 1'b0;
      o_setting_mode <= 1'b0;
      o_disp_kind <= DISP_BLANK;
      o_disp_value <= 7'h00;
    end else begin
      o_start_led <= setting && blink;
      o_buzzer <= (state == ST_BEEP) && !halves[0];
      o_setting_mode <= setting;
      o_disp_kind <= DISP_BLANK;
      o_disp_value <= 7'h00;
      case (state)
        ST_SELECT: begin
          o_disp_kind <= DISP_PARAM;
          o_disp_value <= 7'(sel);
        end
        ST_EDIT: begin
          if (!edit_en) begin
            o_disp_kind <= DISP_OFF;
          end else if (has_speed(sel) && blink) begin
            o_disp_kind <= DISP_NUM;
            o_disp_value <= edit_k;
          end else begin
            o_disp_kind <= DISP_ON;
          end
        end
        ST_CONFIRM: begin
          if (blink) begin
            o_disp_kind <= DISP_PARAM;
            o_disp_value <= 7'(view);
          end else if (!param_en[view]) begin
            o_disp_kind <= DISP_OFF;
          end else if (has_speed(view)) begin
            o_disp_kind <= DISP_NUM;
            o_disp_value <= (view == P_FIXED) ? fixed_k : max_k;
          end else begin
            o_disp_kind <= DISP_ON;
          end
        end
        default: begin
          o_disp_kind <= DISP_BLANK;
        end
      endcase
    end
  end

  // pulse accumulator, saturating so a long burst cannot wrap the speed
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_k <= PULSE_MIN_K;
    end else if (cnt_rise && param_en[P_EXT] && (state == ST_RUN)) begin
      if (i_up_down_select && (pulse_k < SPEED_MAX_K)) begin
        pulse_k <= 7'(pulse_k + 7'h01);
      end else if (!i_up_down_select && (pulse_k > PULSE_MIN_K)) begin
        pulse_k <= 7'(pulse_k - 7'h01);
      end
    end
  end

  // source choice, voltage scaling, lowest limit wins
  always_comb begin
    next_speed = param_en[P_EXT] ? kilo_to_rpm(pulse_k)
                                 : volt_to_rpm(i_voltage_speed_in, param_en[P_SCALE]);
    next_speed = min_rpm(next_speed, ABS_CAP_RPM);
    if (param_en[P_MAX]) begin
      next_speed = min_rpm(next_speed, kilo_to_rpm(max_k));
    end
    if (param_en[P_AIR]) begin
      next_speed = min_rpm(next_speed, AIR_CAP_RPM);
    end
    if (param_en[P_SCALE]) begin
      next_speed = min_rpm(next_speed, SCALE_CAP_RPM);
    end
  end

  // start signalling in auto mode; both forward and reverse at once means stop
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_speed_cmd <= 17'h00000;
      o_run <= 1'b0;
      o_run_reverse <= 1'b0;
      o_air_monitor_en <= 1'b1;
    end else begin
      o_air_monitor_en <= !param_en[P_AIR];
      if ((state == ST_RUN) && i_auto_mode) begin
        o_speed_cmd <= next_speed;
        if (param_en[P_START]) begin
          o_run <= i_forward_start ^ i_reverse_start;
          o_run_reverse <= i_reverse_start;
        end else begin
          o_run <= i_start_in;
          o_run_reverse <= i_dir_in;
        end
      end else begin
        o_speed_cmd <= 17'h00000;
        o_run <= 1'b0;
        o_run_reverse <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

/* spm_chk.sv */
/* assertions on the menu outputs
   assumes it is bound to the menu top, timing parameters handed on */
`timescale 1ns/10ps
`default_nettype none
module spm_chk
  import spm_pkg::*;
#(parameter int BEEP_CYC = BEEP_CYCLES) (
  input wire logic i_clk, // clock
  input wire logic i_rstn, // reset
  input wire logic [2:0] o_disp_kind, // kind
  input wire logic [6:0] o_disp_value, // value
  input wire logic o_buzzer, // buzzer
  input wire logic o_setting_mode, // menu
  input wire logic [16:0] o_speed_cmd, // rpm
  input wire logic o_run, // run
  input wire logic o_air_monitor_en, // air check
  input wire logic o_nv_we, // write
  input wire logic [3:0] o_nv_index // index
);
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);
  int hi_cnt;
  // length of the current beep, cleared between beeps
  always_ff @(posedge i_clk or negedge i_rstn)
    if (!i_rstn) hi_cnt <= 0;
    else hi_cnt <= o_buzzer ? hi_cnt + 1 : 0;
  property p_abs_cap;
    o_speed_cmd <= ABS_CAP_RPM;
  endproperty
  a_abs_cap: assert property (p_abs_cap) else $error("speed over cap");
  property p_air_cap;
    !o_air_monitor_en |-> o_speed_cmd <= AIR_CAP_RPM;
  endproperty
  a_air_cap: assert property (p_air_cap) else $error("air cap missed");
  property p_we_pulse;
    o_nv_we |=> !o_nv_we;
  endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("long write");
  property p_we_menu;
    o_nv_we |-> o_setting_mode && o_nv_index inside {[P_FIRST:P_LAST]};
  endproperty
  a_we_menu: assert property (p_we_menu) else $error("bad write");
  property p_num_range;
    o_disp_kind == DISP_NUM |-> o_disp_value inside {[SPEED_MIN_K:SPEED_MAX_K]};
  endproperty
  a_num_range: assert property (p_num_range) else $error("speed shown out of range");
  property p_code_range;
    o_disp_kind == DISP_PARAM |-> o_disp_value inside {[P_FIRST:P_CONFIRM]};
  endproperty
  a_code_range: assert property (p_code_range) else $error("bad code");
  // the motor must stay still while the menu owns the panel
  property p_menu_still;
    o_setting_mode |-> o_speed_cmd == 17'h00000 && !o_run;
  endproperty
  a_menu_still: assert property (p_menu_still) else $error("runs in menu");
  property p_beep_len;
    $fell(o_buzzer) |-> hi_cnt == BEEP_CYC;
  endproperty
  a_beep_len: assert property (p_beep_len) else $error("beep length");
  property p_beep_first;
    o_buzzer |-> !o_setting_mode;
  endproperty
  a_beep_first: assert property (p_beep_first) else $error("beep in menu");
  c_menu: cover property ($rose(o_setting_mode));
  c_write: cover property (o_nv_we);
  c_beep: cover property ($rose(o_buzzer));
endmodule

bind spindle_param_menu spm_chk #(.BEEP_CYC(BEEP_CYC)) spm_chk_inst (.i_clk, .i_rstn,
  .o_disp_kind, .o_disp_value, .o_buzzer, .o_setting_mode, .o_speed_cmd, .o_run,
  .o_air_monitor_en, .o_nv_we, .o_nv_index);
`default_nettype wire

/* spm_ctrl_model.sv */
/* machine controller driving the connector inputs
   assumes its tasks are called just after a rising edge */
`timescale 1ns/10ps
`default_nettype none
module spm_ctrl_model (
  input wire logic i_clk, // clock
  output logic [13:0] o_mv, // speed, mV
  output logic o_cnt, // count pulse
  output logic o_ud, // high: up
  output logic o_dir, // direction
  output logic o_st, // start
  output logic o_fwd, // forward start
  output logic o_rev // reverse start
);
  initial {o_mv, o_cnt, o_ud, o_dir, o_st, o_fwd, o_rev} = '0;
  task automatic volt(input int mv);
    o_mv = 14'(mv > 10000 ? 10000 : mv);
  endtask
  task automatic pulses(input int n, input logic up);
    o_ud = up;
    repeat (n) begin
      repeat (2) @(posedge i_clk);
      #1 o_cnt = 1;
      repeat (2) @(posedge i_clk);
      #1 o_cnt = 0;
    end
  endtask
  task automatic starts(input logic [3:0] b);
    {o_dir, o_st, o_fwd, o_rev} = b;
  endtask
endmodule
`default_nettype wire

/* tb_spindle_param_menu.sv */
/* self-checking bench for the spindle parameter menu
   assumes shortened timing parameters and the controller model */
`timescale 1ns/10ps
`default_nettype none
module tb_spindle_param_menu
  import spm_pkg::*;
;
  logic clk = 0, rstn = 0, auto = 0, blank = 1, nv_dir = 0, nv_auto = 0;
  logic [2:0] sw = '0; // start, reset, adjust
  logic [8:1] nv_en = '0;
  logic [6:0] nv_fix = 7'h01, nv_max = 7'h50, nv_spd = 7'h01;
  logic [3:0] nv_gear = '0;
  wire logic [13:0] mv;
  wire logic cnt, ud, dir, st, forward_start, rvs;
  logic [2:0] kind;
  logic [6:0] val, spd_w, r_spd;
  logic [16:0] spd;
  logic [3:0] idx, r_gear;
  logic bz, smode, run, reverse_start, air, we, en_w, r_dir, r_auto, led, bz_q = 0;
  logic [11:0] w_cap = '0;
  logic [8:1] cfg [4] = '{8'h80, 8'hc0, 8'h08, 8'h30};
  int failures = 0, num_checks = 0, we_cnt = 0, bz_cnt = 0;

  spindle_param_menu #(.HOLD_CYC(40), .DB_CYC(4), .BLINK_CYC(16), .BEEP_CYC(8))
    spindle_param_menu_inst (.i_clk(clk), .i_rstn(rstn), .i_start_sw(sw[0]),
    .i_reset_sw(sw[1]), .i_adjust_sw(sw[2]), .i_auto_mode(auto), .i_voltage_speed_in(mv),
    .i_count_pulse_in(cnt), .i_up_down_select(ud), .i_dir_in(dir), .i_start_in(st),
    .i_forward_start(forward_start), .i_reverse_start(rvs), .i_nv_blank(blank), .i_nv_enable(nv_en),
    .i_nv_fixed_speed(nv_fix), .i_nv_max_speed(nv_max), .i_nv_panel_speed(nv_spd),
    .i_nv_panel_dir(nv_dir), .i_nv_panel_auto(nv_auto), .i_nv_panel_gear(nv_gear),
    .o_disp_kind(kind), .o_disp_value(val), .o_start_led(led), .o_buzzer(bz),
    .o_setting_mode(smode), .o_speed_cmd(spd), .o_run(run), .o_run_reverse(reverse_start),
    .o_air_monitor_en(air), .o_nv_we(we), .o_nv_index(idx), .o_nv_enable(en_w),
    .o_nv_speed(spd_w), .o_resume_speed(r_spd), .o_resume_dir(r_dir),
    .o_resume_auto(r_auto), .o_resume_gear(r_gear));
  spm_ctrl_model ctrl_inst (.i_clk(clk), .o_mv(mv), .o_cnt(cnt), .o_ud(ud), .o_dir(dir),
    .o_st(st), .o_fwd(forward_start), .o_rev(rvs));

  // 40 MHz clock
  initial forever #12.5 clk = ~clk;
  // count writes and beeps, since the press task hides their timing
  always @(posedge clk) begin
    if (we) begin
      we_cnt++;
      w_cap = {idx, en_w, spd_w};
    end
    if (bz && !bz_q) bz_cnt++;
    bz_q <= bz;
  end

  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    if (failures == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // held past the debounce, so one press is one action
  task automatic press(input int b);
    sw[b] = 1;
    tick(10);
    sw[b] = 0;
    tick(10);
  endtask
  task automatic boot(input logic [8:1] en, input logic bl, input logic hold);
    rstn = 0;
    nv_en = en;
    blank = bl;
    nv_max = 7'($urandom_range(80, 1));
    nv_spd = 7'($urandom_range(80, 1));
    {nv_dir, nv_auto, nv_gear} = 6'($urandom);
    sw = {1'b0, hold, 1'b0};
    tick(8);
    rstn = 1;
    tick(hold ? 110 : 8);
    sw = '0;
    tick(20);
  endtask
  function automatic logic [16:0] exp_speed(input int v, input logic [8:1] en, input int pk);
    int s;
    s = en[5] ? pk * 1000 : (en[8] ? v * 20 / 3 : v * 10);
    if (s > 80000) s = 80000;
    if (en[4] && s > nv_max * 1000) s = nv_max * 1000;
    if (en[7] && s > 30000) s = 30000;
    if (en[8] && s > 60000) s = 60000;
    return 17'(s);
  endfunction
  // voltage, pulse and start checks for one parameter set
  task automatic run_cfg(input logic [8:1] en);
    int v, pk, n;
    logic [3:0] b;
    logic up;
    pk = 0;
    auto = 1;
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 10000 : $urandom_range(10000);
      ctrl_inst.volt(v);
      tick(3);
      chk(spd, exp_speed(v, en, pk));
      b = 4'($urandom);
      ctrl_inst.starts(b);
      tick(3);
      chk({run, reverse_start}, en[6] ? {b[1] ^ b[0], b[0]} : {b[2], b[3]});
    end
    for (int i = 0; i < 3; i++) begin
      n = $urandom_range(4, 1);
      up = (i == 1);
      ctrl_inst.pulses(n, up);
      if (en[5]) pk = up ? pk + n : (pk > n ? pk - n : 0);
      tick(3);
      chk(spd, exp_speed(v, en, pk));
    end
    auto = 0;
    tick(3);
    chk(spd, 17'h00000);
  endtask

  initial begin
    void'($urandom(32'h350d));
    boot(8'hff, 1, 0);
    chk(air, 1'b1);
    run_cfg(8'h00);
    for (int c = 0; c < 4; c++) begin
      boot(cfg[c], 0, 0);
      chk({r_spd, r_dir, r_auto, r_gear}, {nv_spd, nv_dir, nv_auto, nv_gear});
      chk(air, !cfg[c][7]);
      run_cfg(cfg[c]);
    end
    boot(8'h00, 1, 1);
    chk(17'(bz_cnt), 17'h00003);
    chk({smode, kind, val}, {1'b1, DISP_PARAM, 7'h01});
    for (int i = 0; i < 40 && led !== 1'b1; i++) tick(1);
    chk(led, 1'b1);
    repeat (3) press(2);
    chk(val, P_MAX);
    press(0);
    chk(kind, DISP_OFF);
    press(0);
    chk(kind inside {DISP_ON, DISP_NUM}, 1'b1);
    press(2);
    press(1);
    chk(17'(we_cnt), 17'h00001);
    chk(w_cap, {P_MAX, 1'b1, SPEED_MIN_K});
    chk({kind, val}, {DISP_PARAM, 7'h04});
    repeat (5) press(2);
    repeat (4) press(0);
    for (int i = 0; i < 40 && kind !== DISP_NUM; i++) tick(1);
    chk(val, SPEED_MIN_K);
    repeat (5) press(0);
    chk({smode, kind, val}, {1'b1, DISP_PARAM, 7'h01});
    repeat (8) press(2);
    press(0);
    press(1);
    chk({smode, kind, val}, {1'b1, DISP_PARAM, 7'h09});
    summarize();
  end
  // cut a hang short
  initial begin
    repeat (10000) @(posedge clk);
    failures++;
    summarize();
  end
endmodule
`default_nettype wire
